// File: shared/memst_pkg.sv
/*
  memst_pkg: offsets, field positions, reset values and types for the
  memory status register bank.
  assumes: AHB-Lite slave with 32-bit data, one word per register.
*/
package memst_pkg;

  // printed offsets are not multiples of four: index, byte addr = 4*index
  localparam logic [7:0]  MEMST_IDX_RAM_STATUS   = 8'hD5;
  localparam logic [7:0]  MEMST_IDX_SELFTEST_CTL = 8'hD6;
  localparam logic [7:0]  MEMST_IDX_STORE_STATUS = 8'hE1;

  // field positions, self-test status
  localparam int          MEMST_BIT_COMPLETE     = 0;
  localparam int          MEMST_BIT_FAILED       = 1;
  // field positions, self-test control
  localparam int          MEMST_BIT_ENABLE       = 2;
  // field positions, store status
  localparam int          MEMST_BIT_BANK_LO      = 0;
  localparam int          MEMST_BIT_WRITE_ACTIVE = 3;
  localparam int          MEMST_BIT_LOAD_ACTIVE  = 4;
  localparam int          MEMST_BIT_WRITE_OK     = 5;
  localparam int          MEMST_BIT_CHECKSUM_ERR = 6;
  localparam int          MEMST_BIT_TRIM_ERR     = 7;

  // values after reset
  localparam logic [7:0]  MEMST_RST_RAM_STATUS   = 8'h00;
  localparam logic [7:0]  MEMST_RST_STORE_STATUS = 8'h00;
  localparam logic [7:0]  MEMST_RST_CTL          = 8'h00;

  localparam logic [1:0]  MEMST_HTRANS_NONSEQ    = 2'h2;
  localparam logic [1:0]  MEMST_HTRANS_SEQ       = 2'h3;

  // status from the non-volatile store controller
  typedef struct packed {
    logic       trim_err;
    logic       checksum_err;
    logic       store_write_ok;
    logic       store_cache_load_active;
    logic       store_write_active;
    logic [2:0] selected_store_bank;
  } memst_store_type;

  // status from the RAM self-test engine
  typedef struct packed {
    logic ram_selftest_failed;
    logic ram_selftest_complete;
  } memst_bist_type;

endpackage

// File: rtl/memst_regs.sv
/*
  memst_regs: AHB-Lite slave holding the RAM self-test status register,
  the self-test enable and the non-volatile store status register.
  assumes: self-test engine and store controller run on I_CLK, so their
  status needs no synchroniser; single AHB-Lite master, zero wait states.
*/
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/100ps

// Behaviour
// - bit 0 of the RAM self-test status reads 1 once the self-test has finished while the self-test enable is set, else 0.
// - bit 1 of the RAM self-test status reads 1 when the self-test completed and failed while the enable is set, 0 on a clean run.
// - bits 2 to 0 of the store status give the selected bank, codes 0 to 5 meaningful.
// - bit 3 of the store status reads 1 while programming is underway, else 0.
// - bit 4 of the store status reads 1 while contents are moved into the cache, else 0.
// - bit 5 of the store status reads 1 when the last programming succeeded, else 0.
// - bit 6 of the store status reads 1 when the checksum check fails, else 0.
// - bit 7 of the store status reads 1 when the trim value is corrupted, else 0.
// - a set self-test enable starts the self-test and blocks processor RAM access meanwhile.
module memst_regs
  import memst_pkg::*;
(
  // clock and reset
  input  wire logic            I_CLK,
  input  wire logic            I_RST_N,
  // ahb-lite slave
  input  wire logic            I_HSEL,
  input  wire logic [31:0]     I_HADDR,
  input  wire logic [1:0]      I_HTRANS,
  input  wire logic            I_HWRITE,
  input  wire logic [2:0]      I_HSIZE,
  input  wire logic [31:0]     I_HWDATA,
  input  wire logic            I_HREADY,
  output logic      [31:0]     O_HRDATA,
  output logic                 O_HREADYOUT,
  output logic                 O_HRESP,
  // self-test engine
  input  wire memst_bist_type  I_BIST,
  output logic                 O_RAM_SELFTEST_START,
  output logic                 O_RAM_CPU_BLOCK,
  // store controller
  input  wire memst_store_type I_STORE
);

  logic [7:0]  ram_status_q;
  logic [7:0]  ram_status_d;
  logic [7:0]  store_status_q;
  logic [7:0]  store_status_d;
  logic        enable_q;
  logic        enable_d;
  logic        wr_pend_q;
  logic        wr_pend_d;
  logic [7:0]  wr_idx_q;
  logic [7:0]  wr_idx_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic        take;
  logic [7:0]  a_idx;
  logic        a_ok;

  // address decode
  always_comb
  begin
    take  = I_HSEL && I_HREADY &&
            (I_HTRANS == MEMST_HTRANS_NONSEQ || I_HTRANS == MEMST_HTRANS_SEQ);
    a_idx = I_HADDR[9:2];
    a_ok  = (I_HADDR[31:10] == 22'h00_0000);
  end

  // status capture and control write
  always_comb
  begin
    ram_status_d   = MEMST_RST_RAM_STATUS;
    // complete held 0 until engine finishes, and while enable is clear
    ram_status_d[MEMST_BIT_COMPLETE] = enable_q && I_BIST.ram_selftest_complete;
    // fail reported only with complete
    ram_status_d[MEMST_BIT_FAILED]   = enable_q && I_BIST.ram_selftest_complete &&
                                       I_BIST.ram_selftest_failed;
    // store status straight from the controller
    store_status_d = I_STORE;
    enable_d       = enable_q;
    // writes only reach the enable; status bits ignore them
    if (wr_pend_q && wr_idx_q == MEMST_IDX_SELFTEST_CTL)
    begin
      enable_d = I_HWDATA[MEMST_BIT_ENABLE];
    end
    wr_pend_d = take && I_HWRITE && a_ok;
    wr_idx_d  = a_idx;
    rdata_d   = 32'h0000_0000;
    if (take && !I_HWRITE && a_ok)
    begin
      unique case (a_idx)
        MEMST_IDX_RAM_STATUS:   rdata_d = {24'h00_0000, ram_status_d};
        MEMST_IDX_STORE_STATUS: rdata_d = {24'h00_0000, store_status_d};
        MEMST_IDX_SELFTEST_CTL: rdata_d = {29'h0000_0000, enable_q, 2'b00};
        default:                rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge I_CLK)
  begin
    if (!I_RST_N)
    begin
      ram_status_q   <= MEMST_RST_RAM_STATUS;
      store_status_q <= MEMST_RST_STORE_STATUS;
      enable_q       <= MEMST_RST_CTL[MEMST_BIT_ENABLE];
      wr_pend_q      <= 1'b0;
      wr_idx_q       <= 8'h00;
      rdata_q        <= 32'h0000_0000;
    end
    else
    begin
      ram_status_q   <= ram_status_d;
      store_status_q <= store_status_d;
      enable_q       <= enable_d;
      wr_pend_q      <= wr_pend_d;
      wr_idx_q       <= wr_idx_d;
      rdata_q        <= rdata_d;
    end
  end

  // outputs
  assign O_HRDATA             = rdata_q;
  assign O_HREADYOUT          = 1'b1;
  assign O_HRESP              = 1'b0;
  assign O_RAM_SELFTEST_START = enable_q;
  assign O_RAM_CPU_BLOCK      = enable_q;

  // assertions
  sequence s_en_write;
    wr_pend_q && wr_idx_q == MEMST_IDX_SELFTEST_CTL && I_HWDATA[MEMST_BIT_ENABLE];
  endsequence

  property p_enable_blocks;
    @(posedge I_CLK) disable iff (!I_RST_N)
      s_en_write |=> O_RAM_CPU_BLOCK && O_RAM_SELFTEST_START;
  endproperty
  a_enable_blocks: assert property (p_enable_blocks)
    else $error("self-test enable did not block ram");

  property p_complete;
    @(posedge I_CLK) disable iff (!I_RST_N)
      ram_status_q[MEMST_BIT_COMPLETE] ==
      ($past(I_BIST.ram_selftest_complete) && $past(enable_q));
  endproperty
  a_complete: assert property (p_complete)
    else $error("complete flag wrong");

  property p_fail_needs_done;
    @(posedge I_CLK) disable iff (!I_RST_N)
      ram_status_q[MEMST_BIT_FAILED] |-> ram_status_q[MEMST_BIT_COMPLETE];
  endproperty
  a_fail_needs_done: assert property (p_fail_needs_done)
    else $error("fail flag without complete");

  property p_bank;
    @(posedge I_CLK) disable iff (!I_RST_N)
      I_RST_N |=> store_status_q[2:0] == $past(I_STORE.selected_store_bank);
  endproperty
  a_bank: assert property (p_bank)
    else $error("bank field wrong");

  property p_write_active;
    @(posedge I_CLK) disable iff (!I_RST_N)
      I_RST_N && $rose(I_STORE.store_write_active) |=>
        store_status_q[MEMST_BIT_WRITE_ACTIVE];
  endproperty
  a_write_active: assert property (p_write_active)
    else $error("write active bit missed");

  property p_load_active;
    @(posedge I_CLK) disable iff (!I_RST_N)
      $fell(I_STORE.store_cache_load_active) |=> !store_status_q[MEMST_BIT_LOAD_ACTIVE];
  endproperty
  a_load_active: assert property (p_load_active)
    else $error("load active bit stuck");

  property p_write_ok;
    @(posedge I_CLK) disable iff (!I_RST_N)
      I_RST_N && I_STORE.store_write_ok |=> store_status_q[MEMST_BIT_WRITE_OK];
  endproperty
  a_write_ok: assert property (p_write_ok)
    else $error("write ok bit missed");

  property p_checksum;
    @(posedge I_CLK) disable iff (!I_RST_N)
      I_RST_N && I_STORE.checksum_err |=> store_status_q[MEMST_BIT_CHECKSUM_ERR];
  endproperty
  a_checksum: assert property (p_checksum)
    else $error("checksum bit missed");

  property p_trim;
    @(posedge I_CLK) disable iff (!I_RST_N)
      I_RST_N && I_STORE.trim_err |=> store_status_q[MEMST_BIT_TRIM_ERR];
  endproperty
  a_trim: assert property (p_trim)
    else $error("trim bit missed");

  property p_reset_zero;
    @(posedge I_CLK)
      !I_RST_N |=> ram_status_q == 8'h00 && store_status_q == 8'h00;
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("status not zero after reset");

  property p_status_write_ignored;
    @(posedge I_CLK) disable iff (!I_RST_N)
      wr_pend_q && wr_idx_q != MEMST_IDX_SELFTEST_CTL |=> $stable(enable_q);
  endproperty
  a_status_write_ignored: assert property (p_status_write_ignored)
    else $error("status write reached the enable");

  property p_block_holds;
    @(posedge I_CLK) disable iff (!I_RST_N)
      O_RAM_CPU_BLOCK && !(wr_pend_q && wr_idx_q == MEMST_IDX_SELFTEST_CTL) |=>
        O_RAM_CPU_BLOCK;
  endproperty
  a_block_holds: assert property (p_block_holds)
    else $error("ram block dropped while enable kept");

  property p_reset_ctl;
    @(posedge I_CLK)
      !I_RST_N |=> !O_RAM_CPU_BLOCK && O_HRDATA == 32'h0000_0000;
  endproperty
  a_reset_ctl: assert property (p_reset_ctl)
    else $error("enable or read data not cleared by reset");

  sequence s_store_read;
    I_RST_N && take && !I_HWRITE && a_ok && a_idx == MEMST_IDX_STORE_STATUS;
  endsequence

  property p_store_read;
    @(posedge I_CLK) disable iff (!I_RST_N)
      s_store_read |=> O_HRDATA == {24'h00_0000, $past(I_STORE)};
  endproperty
  a_store_read: assert property (p_store_read)
    else $error("store status read wrong");

endmodule

// File: verification/tb.sv
/*
  tb: self-checking bench for the memory status register bank.
  assumes: memst_regs as the one ahb-lite slave, hready tied to its hreadyout.
*/
`timescale 1ns/100ps
module tb
  import memst_pkg::*;
;
  logic            clk;
  logic            rst_n;
  logic            hsel;
  logic            hwrite;
  logic [1:0]      htrans;
  logic [2:0]      hsize;
  logic [31:0]     haddr;
  logic [31:0]     hwdata;
  logic            rd_phase;
  memst_bist_type  bist;
  memst_store_type store;
  wire  [31:0]     hrdata;
  wire             hreadyout;
  wire             hresp;
  wire             st_start;
  wire             cpu_block;
  int              n_mismatch;
  int              total_checks;
  int              cycles;
  logic [31:0]     exp_q[$];
  string           name_q[$];

  memst_regs memst_regs_i (
    .I_CLK(clk), .I_RST_N(rst_n), .I_HSEL(hsel), .I_HADDR(haddr),
    .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(hsize), .I_HWDATA(hwdata),
    .I_HREADY(hreadyout), .O_HRDATA(hrdata), .O_HREADYOUT(hreadyout),
    .O_HRESP(hresp), .I_BIST(bist), .O_RAM_SELFTEST_START(st_start),
    .O_RAM_CPU_BLOCK(cpu_block), .I_STORE(store)
  );

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // one single transfer; reads note their expected word
  task automatic bus(input logic [7:0] idx, input logic wr, input logic [31:0] d,
                     input string nm);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {22'h00_0000, idx, 2'b00};
    htrans <= MEMST_HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    if (!wr)
    begin
      exp_q.push_back(d);
      name_q.push_back(nm);
      rd_phase <= 1'b1;
    end
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd_phase <= 1'b0;
    hsel <= 1'b0;
  endtask

  // takes the oldest note when read data stands
  always @(posedge clk)
  begin
    if (rd_phase === 1'b1 && hreadyout === 1'b1)
    begin
      chk(name_q.pop_front(), hrdata, exp_q.pop_front());
      chk("hresp", {31'h0000_0000, hresp}, 32'h0000_0000);
    end
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_mismatch++;
      results();
    end
  end

  initial
  begin
    logic [7:0] s;
    logic [1:0] b;
    void'($urandom(32'hc41a96a3));
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    bist = '0;
    store = '0;
    rd_phase = 1'b0;
    n_mismatch = 0;
    total_checks = 0;
    cycles = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    // reset values
    bus(MEMST_IDX_RAM_STATUS, 1'b0, 32'h0000_0000, "ram_rst");
    bus(MEMST_IDX_STORE_STATUS, 1'b0, 32'h0000_0000, "store_rst");
    bus(MEMST_IDX_SELFTEST_CTL, 1'b0, 32'h0000_0000, "ctl_rst");
    chk("block_rst", {31'h0000_0000, cpu_block}, 32'h0000_0000);
    // enable starts self-test and blocks ram
    bus(MEMST_IDX_SELFTEST_CTL, 1'b1, 32'h0000_0004, "");
    #1;
    chk("start", {31'h0000_0000, st_start}, 32'h0000_0001);
    chk("block", {31'h0000_0000, cpu_block}, 32'h0000_0001);
    bus(MEMST_IDX_SELFTEST_CTL, 1'b0, 32'h0000_0004, "ctl_rd");
    for (int i = 0; i < 4; i++)
    begin
      b = i[1:0];
      bist <= b;
      bus(MEMST_IDX_RAM_STATUS, 1'b1, 32'hFFFF_FFFF, "");
      bus(MEMST_IDX_RAM_STATUS, 1'b0, {30'h0000_0000, b[1] & b[0], b[0]}, "ram");
    end
    // every bank code, random flags, writes ignored
    for (int i = 0; i < 16; i++)
    begin
      s = {5'($urandom()), i[2:0]};
      store <= s;
      bus(MEMST_IDX_STORE_STATUS, 1'b1, ~{24'h00_0000, s}, "");
      bus(MEMST_IDX_STORE_STATUS, 1'b0, {24'h00_0000, s}, "store");
    end
    // unmapped place
    bus(8'hD7, 1'b1, 32'hFFFF_FFFF, "");
    bus(8'hD7, 1'b0, 32'h0000_0000, "unmapped");
    // disable releases ram, status masked
    bus(MEMST_IDX_SELFTEST_CTL, 1'b1, 32'h0000_0000, "");
    bist <= 2'h3;
    #1;
    chk("block_off", {31'h0000_0000, cpu_block}, 32'h0000_0000);
    chk("start_off", {31'h0000_0000, st_start}, 32'h0000_0000);
    bus(MEMST_IDX_RAM_STATUS, 1'b0, 32'h0000_0000, "ram_off");
    // mid-run reset clears enable and read data
    bus(MEMST_IDX_SELFTEST_CTL, 1'b1, 32'h0000_0004, "");
    bus(MEMST_IDX_RAM_STATUS, 1'b0, 32'h0000_0003, "ram_pre");
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk("rdata_rst", hrdata, 32'h0000_0000);
    chk("block_rst2", {31'h0000_0000, cpu_block}, 32'h0000_0000);
    chk("hready_rst", {31'h0000_0000, hreadyout}, 32'h0000_0001);
    @(posedge clk);
    rst_n <= 1'b1;
    bus(MEMST_IDX_RAM_STATUS, 1'b0, 32'h0000_0000, "ram_rst2");
    bus(MEMST_IDX_SELFTEST_CTL, 1'b0, 32'h0000_0000, "ctl_rst2");
    repeat (2) @(posedge clk);
    results();
  end
endmodule
